/* File: rx_system_data_output.sv */
// Receive system data output: per-link serialisers and byte-interleaved mux buses
`timescale 1ns/1ps
module rx_system_data_output
  import rx_sys_out_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic slot_valid_in,
  input wire slot_s slot_in,
  output logic slot_ready_out,
  input wire cfg_s cfg_in,
  input wire logic link_clk_in,
  input wire logic [NUM_LINKS-1:0] rx_system_clock_in,
  input wire logic mux_rx_system_clock_in,
  input wire logic rx_frame_pulse_in,
  output logic [NUM_LINKS-1:0] rx_system_data_out,
  output logic [NUM_LINKS-1:0] rx_data_oe_out,
  output logic [MUX_BUSES-1:0] mux_rx_data_primary_out,
  output logic [MUX_BUSES-1:0] mux_rx_data_backup_out
);
  slot_s fifo_word;
  logic fifo_valid;
  logic fifo_ready;
  xfer_state_e state;
  slot_s xfer_word;
  logic req_toggle;
  logic ack_meta;
  logic ack_sync;
  logic req_seen;

  rx_slot_fifo #(
    .WIDTH(SLOT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(core_clk_in),
    .rst_in(srst_in),
    .in_valid_in(slot_valid_in),
    .in_ready_out(slot_ready_out),
    .in_data_in(slot_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready),
    .out_data_out(fifo_word)
  );

  assign fifo_ready = state == S_IDLE;

  always_ff @(posedge core_clk_in) begin
    ack_meta <= req_seen;
    ack_sync <= ack_meta;
  end

  // Word is held until the link side acknowledges, so it crosses unsynchronised
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state <= S_IDLE;
      req_toggle <= 1'b0;
      xfer_word <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (fifo_valid) begin
            xfer_word <= fifo_word;
            req_toggle <= ~req_toggle;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (ack_sync == req_toggle) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  property p_req_held;
    @(posedge core_clk_in) disable iff (srst_in)
    (state == S_WAIT && ack_sync != req_toggle) |=> $stable(xfer_word) && $stable(req_toggle);
  endproperty
  a_req_held: assert property (p_req_held) else $error("crossing word changed before acknowledge");

  // Link side: reset, config and all pins pass two flip-flops
  logic rst_meta;
  logic link_rst;
  cfg_s cfg_meta;
  cfg_s cfg;
  logic req_meta;
  logic req_sync;
  logic [NUM_LINKS-1:0] clk_meta;
  logic [NUM_LINKS-1:0] clk_sync;
  logic [NUM_LINKS-1:0] clk_prev;
  logic mclk_meta;
  logic mclk_sync;
  logic mclk_prev;
  logic frame_meta;
  logic frame_sync;

  always_ff @(posedge link_clk_in) begin
    rst_meta <= srst_in;
    link_rst <= rst_meta;
    cfg_meta <= cfg_in;
    cfg <= cfg_meta;
    req_meta <= req_toggle;
    req_sync <= req_meta;
    clk_meta <= rx_system_clock_in;
    clk_sync <= clk_meta;
    clk_prev <= clk_sync;
    mclk_meta <= mux_rx_system_clock_in;
    mclk_sync <= mclk_meta;
    mclk_prev <= mclk_sync;
    frame_meta <= rx_frame_pulse_in;
    frame_sync <= frame_meta;
  end

  logic [NUM_LINKS-1:0] own_edge;
  logic [NUM_LINKS-1:0] eff_edge;
  logic mux_edge;

  assign own_edge = ACTIVE_RISING ? (clk_sync & ~clk_prev) : (~clk_sync & clk_prev);
  assign mux_edge = ACTIVE_RISING ? (mclk_sync & ~mclk_prev) : (~mclk_sync & mclk_prev);

  generate
    for (genvar n = 0; n < NUM_LINKS; n++) begin : g_edge
      assign eff_edge[n] = (cfg.clock_slave[n] & cfg.slave_clock_select[n]) ? own_edge[0] : own_edge[n];
    end
  endgenerate

  // One pending word feeds either the eight serialisers or the mux buses
  slot_s pend_word;
  logic pend_valid;
  logic new_word;
  logic [NUM_LINKS-1:0] have_byte;
  logic take_links;
  logic take_mux;
  slot_s mux_word;
  logic mux_have;
  logic [MUX_CNT_W-1:0] mux_cnt;
  logic [MUX_CNT_W-1:0] mux_pos;
  logic [MUX_BUSES-1:0] next_mux_bit;
  logic [NUM_LINKS-1:0][BYTE_W-1:0] link_byte;
  logic [NUM_LINKS-1:0][BIT_IDX_W-1:0] bit_cnt;

  assign new_word = req_sync ^ req_seen;
  assign take_links = !cfg.mux_mode && pend_valid && !(|have_byte);
  assign take_mux = cfg.mux_mode && pend_valid && !mux_have;

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      req_seen <= 1'b0;
      pend_valid <= 1'b0;
      pend_word <= '0;
    end else begin
      if (new_word && !pend_valid) begin
        pend_word <= xfer_word;
        pend_valid <= 1'b1;
        req_seen <= req_sync;
      end else if (take_links || take_mux) begin
        pend_valid <= 1'b0;
      end
    end
  end

  generate
    for (genvar n = 0; n < NUM_LINKS; n++) begin : g_link
      localparam int BUS = n / LINKS_PER_BUS;
      localparam logic MUX_PIN = (n % LINKS_PER_BUS) < MUX_BUSES;

      always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
          link_byte[n] <= '0;
          bit_cnt[n] <= BIT_CNT_START;
          have_byte[n] <= 1'b0;
        end else if (take_links) begin
          link_byte[n] <= pend_word.bytes[n];
          bit_cnt[n] <= BIT_CNT_START;
          have_byte[n] <= 1'b1;
        end else if (!cfg.mux_mode && eff_edge[n] && have_byte[n]) begin
          bit_cnt[n] <= bit_cnt[n] + BIT_CNT_STEP;
          if (bit_cnt[n] == BIT_CNT_LAST) begin
            have_byte[n] <= 1'b0;
          end
        end
      end

      // Pins not used by the mux buses float in multiplexed mode
      always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
          rx_system_data_out[n] <= IDLE_BIT;
          rx_data_oe_out[n] <= 1'b0;
        end else begin
          rx_data_oe_out[n] <= !cfg.mux_mode || MUX_PIN;
          if (cfg.mux_mode) begin
            if (mux_edge) begin
              rx_system_data_out[n] <= MUX_PIN ? next_mux_bit[BUS] : IDLE_BIT;
            end
          end else if (eff_edge[n]) begin
            // Idle ones on underrun keep one bit per edge
            rx_system_data_out[n] <= have_byte[n] ? link_byte[n][~bit_cnt[n]] : IDLE_BIT;
          end
        end
      end

      property p_own_edge_only;
        @(posedge link_clk_in) disable iff (link_rst)
        (!cfg.mux_mode && !eff_edge[n]) |=> $stable(rx_system_data_out[n]);
      endproperty
      a_own_edge_only: assert property (p_own_edge_only) else $error("link output moved without its edge");
    end
  endgenerate

  // Frame pulse restarts the interleave at link one of each bus
  assign mux_pos = frame_sync ? MUX_CNT_START : mux_cnt;

  generate
    for (genvar b = 0; b < MUX_BUSES; b++) begin : g_bus
      localparam logic [BIT_IDX_W-1:0] BASE = BIT_IDX_W'(b * LINKS_PER_BUS);
      assign next_mux_bit[b] = mux_have ? mux_word.bytes[BASE + {1'b0, mux_pos[4:3]}][~mux_pos[2:0]] : IDLE_BIT;
    end
  endgenerate

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      mux_word <= '0;
      mux_have <= 1'b0;
      mux_cnt <= MUX_CNT_START;
    end else if (take_mux) begin
      mux_word <= pend_word;
      mux_have <= 1'b1;
      mux_cnt <= MUX_CNT_START;
    end else if (cfg.mux_mode && mux_edge) begin
      mux_cnt <= mux_pos + MUX_CNT_STEP;
      if (mux_pos == MUX_CNT_LAST) begin
        mux_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      mux_rx_data_primary_out <= {MUX_BUSES{IDLE_BIT}};
      mux_rx_data_backup_out <= {MUX_BUSES{IDLE_BIT}};
    end else if (cfg.mux_mode && mux_edge) begin
      mux_rx_data_primary_out <= next_mux_bit;
      mux_rx_data_backup_out <= next_mux_bit;
    end
  end

  logic exp_bus1_bit;
  assign exp_bus1_bit = mux_word.bytes[BUS1_FIRST_LINK + {1'b0, mux_cnt[4:3]}][~mux_cnt[2:0]];

  property p_slave_follow;
    @(posedge link_clk_in) disable iff (link_rst)
    (!cfg.mux_mode && cfg.clock_slave[4] && cfg.slave_clock_select[4] && !own_edge[0])
      |=> $stable(rx_system_data_out[4]);
  endproperty
  a_slave_follow: assert property (p_slave_follow) else $error("slaved link ignored link one clock");

  property p_select_local;
    @(posedge link_clk_in) disable iff (link_rst)
    (!cfg.mux_mode && !(cfg.clock_slave[5] && cfg.slave_clock_select[5]) && !own_edge[5])
      |=> $stable(rx_system_data_out[5]);
  endproperty
  a_select_local: assert property (p_select_local) else $error("link select leaked from another link");

  property p_bus1_interleave;
    @(posedge link_clk_in) disable iff (link_rst)
    (cfg.mux_mode && mux_edge && mux_have && !frame_sync && !take_mux)
      |=> mux_rx_data_primary_out[1] == $past(exp_bus1_bit);
  endproperty
  a_bus1_interleave: assert property (p_bus1_interleave) else $error("bus two carried wrong link bit");

  property p_mux_edge_only;
    @(posedge link_clk_in) disable iff (link_rst)
    !mux_edge |=> $stable(mux_rx_data_primary_out) && $stable(mux_rx_data_backup_out);
  endproperty
  a_mux_edge_only: assert property (p_mux_edge_only) else $error("mux bus moved without mux clock edge");

  property p_backup_equal;
    @(posedge link_clk_in) disable iff (link_rst)
    mux_rx_data_backup_out == mux_rx_data_primary_out;
  endproperty
  a_backup_equal: assert property (p_backup_equal) else $error("backup bus differs from primary");

  property p_one_bit_step;
    @(posedge link_clk_in) disable iff (link_rst)
    (!cfg.mux_mode && !take_links && eff_edge[2] && have_byte[2]) |=> bit_cnt[2] == $past(bit_cnt[2]) + BIT_CNT_STEP;
  endproperty
  a_one_bit_step: assert property (p_one_bit_step) else $error("bit counter did not step by one");

  property p_frame_realign;
    @(posedge link_clk_in) disable iff (link_rst)
    (cfg.mux_mode && mux_edge && frame_sync && !take_mux) |=> mux_cnt == MUX_CNT_STEP;
  endproperty
  a_frame_realign: assert property (p_frame_realign) else $error("frame pulse did not restart interleave");
endmodule : rx_system_data_output

/* File: rx_sys_out_pkg.sv */
// Constants, carriers and states shared by the receive system data output
package rx_sys_out_pkg;
  localparam int NUM_LINKS = 8;
  localparam int BYTE_W = 8;
  localparam int BIT_IDX_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int LINKS_PER_BUS = 4;
  localparam int MUX_BUSES = 2;
  localparam int MUX_CNT_W = 5;
  localparam int LINK_SEL_W = 2;
  localparam logic [MUX_CNT_W-1:0] MUX_CNT_START = 5'h00;
  localparam logic [MUX_CNT_W-1:0] MUX_CNT_LAST = 5'h1f;
  localparam logic [BIT_IDX_W-1:0] BIT_CNT_START = 3'h0;
  localparam logic [BIT_IDX_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [BIT_IDX_W-1:0] BIT_CNT_STEP = 3'h1;
  localparam logic [MUX_CNT_W-1:0] MUX_CNT_STEP = 5'h01;
  localparam logic [BIT_IDX_W-1:0] BUS1_FIRST_LINK = 3'h4;
  localparam logic IDLE_BIT = 1'b1;
  localparam logic ACTIVE_RISING = 1'b1;
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int FRAME_PERIOD_NS = 125000;

  typedef struct packed {
    logic [NUM_LINKS-1:0][BYTE_W-1:0] bytes;
  } slot_s;

  localparam int SLOT_W = NUM_LINKS * BYTE_W;

  typedef struct packed {
    logic mux_mode;
    logic [NUM_LINKS-1:0] clock_slave;
    logic [NUM_LINKS-1:0] slave_clock_select;
  } cfg_s;

  localparam int CFG_W = 1 + 2 * NUM_LINKS;

  typedef enum logic {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } xfer_state_e;
endpackage : rx_sys_out_pkg

/* File: rx_slot_fifo.sv */
// Parameterised flip-flop FIFO holding timeslot words
`timescale 1ns/1ps
module rx_slot_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  // Depth must be a power of two; pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] ONE_COUNT = (AW + 1)'(1);
  localparam logic [AW-1:0] ONE_PTR = AW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + ONE_COUNT;
    end else if (pop && !push) begin
      next_count = count - ONE_COUNT;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_out <= next_count != FULL_COUNT;
      out_valid_out <= next_count != '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + ONE_PTR;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + ONE_PTR;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  property p_fifo_bound;
    @(posedge clk_in) disable iff (rst_in)
    (count == FULL_COUNT) |-> !in_ready_out;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo accepts while full");
endmodule : rx_slot_fifo

/* File: far_end_model.sv */
// Backplane-side model: pin clocks, frame pulse and bit capture
`timescale 1ns/1ps
module far_end_model
  import rx_sys_out_pkg::*;
(
  input wire logic [NUM_LINKS-1:0] follow_one_in,
  input wire logic [NUM_LINKS-1:0] data_in,
  input wire logic [MUX_BUSES-1:0] primary_in,
  input wire logic [MUX_BUSES-1:0] backup_in,
  output logic [NUM_LINKS-1:0] pin_clk_out,
  output logic mux_clk_out,
  output logic frame_out
);
  // Slow pin clocks, since the block oversamples them
  localparam int HALF_NS = 240;
  logic link_q[NUM_LINKS][$];
  logic mux_q[MUX_BUSES][$];
  int copy_diffs;
  initial begin
    pin_clk_out = '0;
    mux_clk_out = 1'b0;
    frame_out = 1'b0;
    copy_diffs = 0;
  end
  // Clocks stand still between bursts; sampling half a period after the edge
  task automatic run_links(input logic [NUM_LINKS-1:0] mask, input int edges);
    for (int e = 0; e < edges; e++) begin
      pin_clk_out = mask;
      #HALF_NS;
      pin_clk_out = '0;
      for (int n = 0; n < NUM_LINKS; n++) begin
        if (follow_one_in[n] ? mask[0] : mask[n]) begin
          link_q[n].push_back(data_in[n]);
        end
      end
      #HALF_NS;
    end
  endtask : run_links
  task automatic run_mux(input int edges);
    for (int e = 0; e < edges; e++) begin
      frame_out = (e == 0);
      #HALF_NS;
      mux_clk_out = 1'b1;
      #HALF_NS;
      mux_clk_out = 1'b0;
      frame_out = 1'b0;
      for (int b = 0; b < MUX_BUSES; b++) begin
        mux_q[b].push_back(primary_in[b]);
      end
      if (backup_in !== primary_in) begin
        copy_diffs++;
      end
      // Shared pins carry the bus bits as well
      if (data_in[1:0] !== {2{primary_in[0]}} || data_in[5:4] !== {2{primary_in[1]}}) begin
        copy_diffs++;
      end
    end
  endtask : run_mux
endmodule : far_end_model

/* File: tb.sv */
// Testbench for the receive system data output
`timescale 1ns/1ps
module tb;
  import rx_sys_out_pkg::*;
  logic core_clk_in;
  logic srst_in;
  logic link_clk_in;
  logic slot_valid_in;
  slot_s slot_in;
  cfg_s cfg_in;
  logic slot_ready_out;
  logic mux_clk;
  logic frame;
  logic [NUM_LINKS-1:0] pin_clk;
  logic [NUM_LINKS-1:0] data_out;
  logic [NUM_LINKS-1:0] oe;
  logic [MUX_BUSES-1:0] primary;
  logic [MUX_BUSES-1:0] backup;
  int fails;
  int num_checks;

  rx_system_data_output dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .slot_valid_in(slot_valid_in),
    .slot_in(slot_in), .slot_ready_out(slot_ready_out), .cfg_in(cfg_in), .link_clk_in(link_clk_in),
    .rx_system_clock_in(pin_clk), .mux_rx_system_clock_in(mux_clk), .rx_frame_pulse_in(frame),
    .rx_system_data_out(data_out), .rx_data_oe_out(oe), .mux_rx_data_primary_out(primary),
    .mux_rx_data_backup_out(backup));
  far_end_model far (.follow_one_in(cfg_in.clock_slave & cfg_in.slave_clock_select), .data_in(data_out),
    .primary_in(primary), .backup_in(backup), .pin_clk_out(pin_clk), .mux_clk_out(mux_clk), .frame_out(frame));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Link clock offset so its edges never line up with the core clock
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #15 link_clk_in = ~link_clk_in;
  end

  task automatic print_verdict();
    $display("checks %0d, fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  function automatic logic [7:0] pat(input int k, input int n);
    return 8'(k) * 8'h1d + 8'(n) * 8'h43 + 8'h5a;
  endfunction : pat

  function automatic slot_s word(input int k);
    slot_s w;
    for (int n = 0; n < NUM_LINKS; n++) begin
      w.bytes[n] = pat(k, n);
    end
    return w;
  endfunction : word

  // Reset crosses by two flops, so it is timed on the link clock
  task automatic do_reset(input cfg_s c);
    @(negedge core_clk_in);
    cfg_in = c;
    srst_in = 1'b1;
    repeat (8) @(negedge link_clk_in);
    @(negedge core_clk_in);
    srst_in = 1'b0;
    repeat (10) @(negedge link_clk_in);
    @(negedge core_clk_in);
    for (int n = 0; n < NUM_LINKS; n++) begin
      far.link_q[n].delete();
    end
    far.mux_q[0].delete();
    far.mux_q[1].delete();
  endtask : do_reset

  // Called at a falling edge; valid is held until ready is seen high
  task automatic push_word(input slot_s w, input int limit, output bit ok);
    ok = 1'b0;
    slot_in = w;
    slot_valid_in = 1'b1;
    for (int i = 0; i < limit && !ok; i++) begin
      if (slot_ready_out === 1'b1) begin
        ok = 1'b1;
      end
      @(negedge core_clk_in);
    end
  endtask : push_word

  task automatic take_byte(input bit is_mux, input int idx, output logic [7:0] b);
    b = 'x;
    for (int i = 0; i < BYTE_W; i++) begin
      if (is_mux) begin
        b = {b[6:0], far.mux_q[idx].size() > 0 ? far.mux_q[idx].pop_front() : 1'bx};
      end else begin
        b = {b[6:0], far.link_q[idx].size() > 0 ? far.link_q[idx].pop_front() : 1'bx};
      end
    end
  endtask : take_byte

  task automatic t_fill_drain();
    int taken;
    bit ok;
    logic [7:0] b;
    taken = 0;
    ok = 1'b1;
    do_reset(cfg_s'{1'b0, 8'h00, 8'h00});
    chk("oe master", 8'hff, oe);
    while (ok && taken < 20) begin
      push_word(word(taken), 30, ok);
      if (ok) taken++;
    end
    slot_valid_in = 1'b0;
    // FIFO plus crossing, pending and serialiser words
    chk("accepted", 8'(FIFO_DEPTH + 3), 8'(taken));
    chk("ready full", 8'h00, 8'(slot_ready_out));
    far.run_links(8'hff, 8 * taken);
    for (int k = 0; k < taken; k++) begin
      for (int n = 0; n < NUM_LINKS; n++) begin
        take_byte(1'b0, n, b);
        chk("link byte", pat(k, n), b);
      end
    end
    chk("ready drained", 8'h01, 8'(slot_ready_out));
    // Underrun sends ones
    far.run_links(8'hff, 8);
    for (int n = 0; n < NUM_LINKS; n++) begin
      take_byte(1'b0, n, b);
      chk("underrun byte", 8'hff, b);
    end
  endtask : t_fill_drain

  task automatic t_slave();
    bit ok;
    logic [7:0] b;
    do_reset(cfg_s'{1'b0, 8'hff, 8'hf0});
    push_word(word(40), 30, ok);
    slot_valid_in = 1'b0;
    repeat (40) @(negedge core_clk_in);
    far.run_links(8'h01, 8);
    for (int n = 0; n < NUM_LINKS; n++) begin
      if (n == 0 || n > 3) begin
        take_byte(1'b0, n, b);
        chk("follower byte", pat(40, n), b);
      end
    end
    chk("own clock links held", 8'h07, 8'(data_out[3:1]));
    far.run_links(8'h0e, 8);
    for (int n = 1; n < 4; n++) begin
      take_byte(1'b0, n, b);
      chk("own clock byte", pat(40, n), b);
    end
  endtask : t_slave

  task automatic t_mux();
    bit ok;
    logic [7:0] b;
    do_reset(cfg_s'{1'b1, 8'h00, 8'h00});
    chk("oe mux", 8'h33, oe);
    push_word(word(50), 30, ok);
    slot_valid_in = 1'b0;
    repeat (40) @(negedge core_clk_in);
    far.run_mux(32);
    for (int bus = 0; bus < MUX_BUSES; bus++) begin
      for (int l = 0; l < LINKS_PER_BUS; l++) begin
        take_byte(1'b1, bus, b);
        chk("mux byte", pat(50, bus * LINKS_PER_BUS + l), b);
      end
    end
    chk("backup differs", 8'h00, 8'(far.copy_diffs));
  endtask : t_mux

  initial begin
    fails = 0;
    num_checks = 0;
    srst_in = 1'b1;
    slot_valid_in = 1'b0;
    slot_in = '0;
    cfg_in = '0;
    t_fill_drain();
    t_slave();
    t_mux();
    print_verdict();
  end

  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule : tb
